/* File: rtl/hc_posted_write_error_and_control.sv */
`timescale 1ns/1ps
`include "hc_regs_defines.svh"

module hc_posted_write_error_and_control
#(
  // byte address width of the register port
  parameter int ADDR_BITS = `ADDR_W
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register port
  input wire logic [ADDR_BITS-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // posted write failure report
  input wire logic pw_fail,
  input wire hc_regs_pkg::pw_error_t pw_fail_info,
  // soft reset request from lower control logic
  input wire logic soft_reset,
  // eeprom load result
  input wire logic eeprom_done,
  input wire logic eeprom_grant,
  // control outputs
  output hc_regs_pkg::ctrl_t ctrl,
  output logic link_connected,
  output logic irq
);
  import hc_regs_pkg::*;

  ////////////////////////////////////////////////////////////////
  // decode

  logic [31:0] err_high_q;
  logic [31:0] err_low_q;
  logic swap_dis_q;
  logic grant_q;
  logic enh_on_q;
  logic link_en_q;
  logic [`INT_W-1:0] int_stat_q;
  logic [`INT_W-1:0] int_mask_q;
  logic [31:0] reg_rdata_q;
  init_state_t state_q;
  init_state_t state_d;

  // one offset compare, shared by strobes and read mux
  function automatic logic addr_hit(input logic [ADDR_BITS-1:0] a, input logic [7:0] off);
    return a == ADDR_BITS'(off);
  endfunction : addr_hit

  wire sel_set = reg_wr && addr_hit(reg_addr, `OFF_CTRL_SET);
  wire sel_clr = reg_wr && addr_hit(reg_addr, `OFF_CTRL_CLR);
  wire sel_stat = reg_wr && addr_hit(reg_addr, `OFF_INT_STATUS);
  wire sel_mask = reg_wr && addr_hit(reg_addr, `OFF_INT_MASK);
  wire set_swap = sel_set && reg_wdata[`BIT_SWAP_DIS];
  wire clr_swap = sel_clr && reg_wdata[`BIT_SWAP_DIS];
  wire set_link = sel_set && reg_wdata[`BIT_LINK_EN];
  wire clr_link = sel_clr && reg_wdata[`BIT_LINK_EN];
  wire link_next = (link_en_q || set_link) && !clr_link;
  // enhance-on may only rise while grant and link are both up
  wire enh_ok = grant_q && link_en_q;
  wire set_enh = sel_set && reg_wdata[`BIT_ENH_ON] && enh_ok;
  wire clr_enh = sel_clr && reg_wdata[`BIT_ENH_ON];
  // grant is clear-only from software
  wire clr_grant = sel_clr && reg_wdata[`BIT_CFG_GRANT];
  wire grant_load = (state_q == ST_LOAD) && eeprom_done;

  // reserved bits fall out as zero from this assembly
  wire [31:0] ctrl_word = {1'b0, swap_dis_q, 6'h00, grant_q, enh_on_q, 4'h0,
    link_en_q, 17'h00000};

  wire [`INT_W-1:0] int_events = {grant_load, pw_fail};
  wire [`INT_W-1:0] int_clr = sel_stat ? reg_wdata[`INT_W-1:0] : {`INT_W{1'b0}};
  // event in the clearing cycle wins
  wire [`INT_W-1:0] int_stat_d = (int_stat_q & ~int_clr) | int_events;

  logic [31:0] rd_mux;
  always_comb
  begin
    if (addr_hit(reg_addr, `OFF_PW_ERR_HIGH))
    begin
      rd_mux = err_high_q;
    end
    else if (addr_hit(reg_addr, `OFF_PW_ERR_LOW))
    begin
      rd_mux = err_low_q;
    end
    else if (addr_hit(reg_addr, `OFF_VENDOR_IDENTITY))
    begin
      rd_mux = `VENDOR_VALUE;
    end
    else if (addr_hit(reg_addr, `OFF_CTRL_SET) || addr_hit(reg_addr, `OFF_CTRL_CLR))
    begin
      rd_mux = ctrl_word;
    end
    else if (addr_hit(reg_addr, `OFF_INT_STATUS))
    begin
      rd_mux = {{(32-`INT_W){1'b0}}, int_stat_q};
    end
    else if (addr_hit(reg_addr, `OFF_INT_MASK))
    begin
      rd_mux = {{(32-`INT_W){1'b0}}, int_mask_q};
    end
    else
    begin
      rd_mux = 32'h00000000;
    end
  end

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_RESET: state_d = ST_LOAD;
      ST_LOAD: if (eeprom_done) state_d = ST_RUN;
      ST_RUN: state_d = ST_RUN;
      default: state_d = ST_RESET;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // registers

  // capture has no reset: value is undefined until the first error
  always_ff @(posedge clk_sys)
  begin
    if (pw_fail)
    begin
      err_high_q <= {pw_fail_info.requester_node_number, pw_fail_info.dest_offset_upper};
    end
  end

  // lower word is taken by the same failure
  always_ff @(posedge clk_sys)
  begin
    if (pw_fail)
    begin
      err_low_q <= pw_fail_info.dest_offset_lower;
    end
  end

  ////////////////////////////////////////////////////////////////
  // next values

  logic grant_d;
  logic swap_dis_d;
  logic link_en_d;
  logic enh_on_d;
  logic [`INT_W-1:0] int_mask_d;
  logic [31:0] reg_rdata_d;
  logic irq_d;

  always_comb
  begin
    grant_d = grant_q;
    if (grant_load)
      grant_d = eeprom_grant;
    else if (clr_grant)
      grant_d = 1'b0;
  end

  assign swap_dis_d = (swap_dis_q || set_swap) && !clr_swap;
  assign link_en_d = soft_reset ? 1'b0 : link_next;
  // a later drop of link or grant leaves enhance-on alone; only clear, soft reset or rstn ends it
  assign enh_on_d = (enh_on_q || set_enh) && !clr_enh && !soft_reset;
  assign int_mask_d = sel_mask ? reg_wdata[`INT_W-1:0] : int_mask_q;
  // read data stand one cycle, zero otherwise
  assign reg_rdata_d = reg_rd ? rd_mux : 32'h00000000;
  // irq follows the status update of this same edge
  assign irq_d = |(int_stat_d & int_mask_q);

  ////////////////////////////////////////////////////////////////
  // elaboration checks

  // offsets are 8-bit; a narrower port cannot reach them
  if (ADDR_BITS < 8 || ADDR_BITS > 32)
  begin : g_bad_addr_bits
    $error("register address width out of range");
  end

  // status and mask live in the low bits of one word
  if (`INT_W < 1 || `INT_W > 32)
  begin : g_bad_event_bits
    $error("event count out of range");
  end

  // the read word is assembled by hand at these positions
  if (`BIT_SWAP_DIS != 30 || `BIT_CFG_GRANT != 23 || `BIT_ENH_ON != 22 || `BIT_LINK_EN != 17)
  begin : g_bad_layout
    $error("control bit layout differs from read word");
  end

  // settable bits must match the set/clear decode
  if (`CTRL_RW_MASK != ((32'h1 << `BIT_SWAP_DIS) | (32'h1 << `BIT_ENH_ON) | (32'h1 << `BIT_LINK_EN)))
  begin : g_bad_rw_mask
    $error("settable control mask differs from decode");
  end

  ////////////////////////////////////////////////////////////////
  // control and status flops

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state_q <= ST_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // software can only clear the grant
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      grant_q <= 1'b0;
    end
    else
    begin
      grant_q <= grant_d;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      swap_dis_q <= 1'b0;
    end
    else
    begin
      swap_dis_q <= swap_dis_d;
    end
  end

  // both hardware and soft reset drop the link
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      link_en_q <= 1'b0;
    end
    else
    begin
      link_en_q <= link_en_d;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      enh_on_q <= 1'b0;
    end
    else
    begin
      enh_on_q <= enh_on_d;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      int_mask_q <= {`INT_W{1'b0}};
    end
    else
    begin
      int_mask_q <= int_mask_d;
    end
  end

  // one cycle of read latency keeps the bus output on a flop
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      reg_rdata_q <= 32'h00000000;
    end
    else
    begin
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // registered so the interrupt pin never glitches
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= irq_d;
    end
  end

  // one flop per event bit; set beats a same-cycle clear
  for (genvar i = 0; i < `INT_W; i++)
  begin : g_event
    always_ff @(posedge clk_sys)
    begin
      if (!rstn)
      begin
        int_stat_q[i] <= 1'b0;
      end
      else
      begin
        int_stat_q[i] <= int_stat_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata = reg_rdata_q;
  assign ctrl.data_swap_disable = swap_dis_q;
  assign ctrl.phy_enhance_config_grant = grant_q;
  assign ctrl.phy_enhance_on = enh_on_q;
  assign ctrl.link_active_enable = link_en_q;
  // low link enable means no packet moves on the bus
  assign link_connected = link_en_q;

endmodule : hc_posted_write_error_and_control

/* File: common/hc_regs_defines.svh */
`ifndef HC_REGS_DEFINES_SVH
`define HC_REGS_DEFINES_SVH

`define ADDR_W 8
`define OFF_PW_ERR_LOW 8'h38
`define OFF_PW_ERR_HIGH 8'h3C
`define OFF_VENDOR_IDENTITY 8'h40
`define OFF_CTRL_SET 8'h50
`define OFF_CTRL_CLR 8'h54
`define OFF_INT_STATUS 8'h80
`define OFF_INT_MASK 8'h84
`define OFF_ERR_INJECT 8'h88
`define BIT_SWAP_DIS 30
`define BIT_CFG_GRANT 23
`define BIT_ENH_ON 22
`define BIT_LINK_EN 17
`define CTRL_RW_MASK 32'h40420000
`define VENDOR_VALUE 32'h00000000
`define INT_PW_ERR 0
`define INT_GRANT_LOAD 1
`define INT_W 2

`endif

/* File: common/hc_regs_pkg.sv */
package hc_regs_pkg;

  typedef struct packed {
    logic [15:0] requester_node_number;
    logic [15:0] dest_offset_upper;
    logic [31:0] dest_offset_lower;
  } pw_error_t;

  typedef struct packed {
    logic data_swap_disable;
    logic phy_enhance_config_grant;
    logic phy_enhance_on;
    logic link_active_enable;
  } ctrl_t;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_LOAD,
    ST_RUN
  } init_state_t;

endpackage : hc_regs_pkg

/* File: verif/hc_chk_properties.sv */
`timescale 1ns/1ps
module hc_chk
(
  // watched ports
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic pw_fail,
  input wire hc_regs_pkg::pw_error_t pw_fail_info,
  input wire logic soft_reset,
  input wire hc_regs_pkg::ctrl_t ctrl,
  input wire logic link_connected
);
  wire [31:0] pw_hi = pw_fail_info[63:32];
  wire [31:0] pw_lo = pw_fail_info[31:0];
  wire [31:0] cb = {1'b0, ctrl.data_swap_disable, 6'h0, ctrl.phy_enhance_config_grant, ctrl.phy_enhance_on, 4'h0,
    ctrl.link_active_enable, 17'h0};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  vendor_zero_a:
  assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == 32'h0) else $error("vendor not zero");
  ctrl_rsvd_a:
  assert property (reg_rd && reg_addr[7:3] == 5'h0A |=> reg_rdata[31] == 1'b0 && reg_rdata[29:24] == 6'h0)
    else $error("reserved control bits set");
  err_high_a:
  assert property (pw_fail ##1 (reg_rd && reg_addr == 8'h3C && !pw_fail) |=> reg_rdata == $past(pw_hi, 2))
    else $error("upper error capture wrong");
  err_low_a:
  assert property (pw_fail ##1 (reg_rd && reg_addr == 8'h38 && !pw_fail) |=> reg_rdata == $past(pw_lo, 2))
    else $error("lower error capture wrong");
  enh_refuse_a:
  assert property (reg_wr && reg_addr == 8'h50 && reg_wdata[22] && !ctrl.phy_enhance_on &&
    !(ctrl.phy_enhance_config_grant && ctrl.link_active_enable) |=> !ctrl.phy_enhance_on) else $error("enhance set");
  link_follow_a:
  assert property (reg_wr && reg_addr == 8'h50 && reg_wdata[17] && !soft_reset |=> link_connected)
    else $error("link not connected after set");
  soft_link_a:
  assert property (soft_reset |=> !ctrl.link_active_enable && !ctrl.phy_enhance_on) else $error("soft reset kept link");
  swap_set_a:
  assert property (reg_wr && reg_addr == 8'h50 && reg_wdata[30] |=> ctrl.data_swap_disable) else $error("swap not set");
  ctrl_clear_a:
  assert property (reg_wr && reg_addr == 8'h54 |=> (cb & $past(reg_wdata)) == 32'h0) else $error("bit not cleared");
endmodule : hc_chk

/* File: verif/tb_hc_posted_write_error_and_control.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; $display("wrong value at %0t: %h %h", $time, a, b); end end
module tb_hc_posted_write_error_and_control;
  import hc_regs_pkg::*;
  logic clk_sys = 0, rstn = 0, reg_wr = 0, reg_rd = 0, pw_fail = 0, soft_reset = 0, eeprom_done = 0, eeprom_grant = 1;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata;
  pw_error_t pw_fail_info = '0, exp;
  ctrl_t ctrl;
  logic link_connected, irq;
  int err_count = 0, check_count = 0, seed = 33;
  hc_posted_write_error_and_control u_hc_posted_write_error_and_control (.clk_sys, .rstn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .pw_fail, .pw_fail_info, .soft_reset, .eeprom_done, .eeprom_grant, .ctrl,
    .link_connected, .irq);
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    `CHK(reg_rdata, e)
  endtask : rd
  task test_done;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  function automatic logic [31:0] hi_word(input pw_error_t p);
    return {p.requester_node_number, p.dest_offset_upper};
  endfunction : hi_word
  initial forever #20 clk_sys = ~clk_sys;
  // hang guard: the run needs far fewer cycles
  initial
  begin
    repeat (4000) @(posedge clk_sys);
    err_count++;
    test_done;
  end
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    eeprom_done <= 1'b1;
    @(posedge clk_sys);
    eeprom_done <= 1'b0;
    rd(8'h50, 32'h00800000);
    wr(8'h40, $random(seed));
    rd(8'h40, 32'h0);
    rd(8'h88, 32'h0);
    wr(8'h50, 32'h00400000);
    rd(8'h54, 32'h00800000);
    wr(8'h50, 32'h00020000);
    wr(8'h50, ($random(seed) & 32'hBF00FFFF) | 32'h40400000);
    rd(8'h50, 32'h40C20000);
    `CHK(ctrl, 4'hF)
    // grant now clear: a conforming driver leaves bit 22 alone, next write probes refusal
    wr(8'h54, 32'h40C00000);
    wr(8'h50, 32'h00400000);
    rd(8'h50, 32'h00020000);
    `CHK(link_connected, 1'b1)
    @(posedge clk_sys);
    soft_reset <= 1'b1;
    @(posedge clk_sys);
    soft_reset <= 1'b0;
    rd(8'h54, 32'h0);
    wr(8'h50, 32'h00020000);
    wr(8'h54, 32'h00020000);
    rd(8'h50, 32'h0);
    $display("control test done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      pw_fail <= 1'b1;
      pw_fail_info <= {$random(seed), $random(seed)};
      @(posedge clk_sys);
      pw_fail <= 1'b0;
      exp = pw_fail_info;
      // read straight after the capture edge
      reg_rd <= 1'b1;
      reg_addr <= i[0] ? 8'h38 : 8'h3C;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      `CHK(reg_rdata, i[0] ? exp[31:0] : hi_word(exp))
      wr(8'h3C, $random(seed));
      rd(8'h3C, hi_word(exp));
      rd(8'h38, exp[31:0]);
    end
    $display("error test done");
    `CHK(irq, 1'b0)
    wr(8'h84, 32'h1);
    repeat (2) @(negedge clk_sys);
    `CHK(irq, 1'b1)
    rd(8'h80, 32'h3);
    wr(8'h80, 32'h1);
    repeat (2) @(negedge clk_sys);
    `CHK(irq, 1'b0)
    $display("interrupt test done");
    test_done;
  end
endmodule : tb_hc_posted_write_error_and_control
bind hc_posted_write_error_and_control hc_chk u_chk (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .pw_fail, .pw_fail_info, .soft_reset, .ctrl, .link_connected);
